// ===== verilog/dqcsr_pkg.sv
`default_nettype none
package dqcsr_pkg;
    // Bank placement inside the relocatable register window
    localparam logic [31:0] BANK_OFS   = 32'h0002_8000;
    localparam int          WIN_LSB    = 19;
    localparam int          BANK_LSB   = 5;
    // Register offsets inside the bank
    localparam logic [4:0]  OFS_WIN    = 5'h00;
    localparam logic [4:0]  OFS_RST    = 5'h04;
    localparam logic [4:0]  OFS_DBASE  = 5'h0c;
    localparam logic [4:0]  OFS_CBASE  = 5'h10;
    localparam logic [4:0]  OFS_DEPTH  = 5'h14;
    localparam logic [4:0]  OFS_DIDX   = 5'h18;
    localparam logic [4:0]  OFS_CIDX   = 5'h1c;
    // Field positions
    localparam int          HOLD_BIT   = 31;
    localparam int          RST_BIT    = 0;
    localparam int          RBASE_LSB  = 12;
    localparam int          HI_LSB     = 16;
    // Values after reset
    localparam logic [12:0] WIN_RST    = 13'h0000;
    localparam logic [19:0] DBASE_RST  = 20'h00000;
    localparam logic [19:0] CBASE_RST  = 20'h00000;
    localparam logic [8:0]  DDEPTH_RST = 9'h100;
    localparam logic [8:0]  CDEPTH_RST = 9'h100;
    localparam logic [7:0]  IDX_RST    = 8'h00;

    // Register interface selected for the device
    typedef enum logic [1:0] {
        DQCSR_IF_APB   = 2'b00,
        DQCSR_IF_AHBL  = 2'b01,
        DQCSR_IF_OTHER = 2'b10
    } dqcsr_if_t;

    // Ring view handed to the core
    typedef struct packed {
        logic [19:0] base;
        logic [8:0]  depth;
        logic [7:0]  prod;
        logic [7:0]  cons;
        logic        empty;
        logic        full;
    } dqcsr_ring_t;
endpackage
`default_nettype wire

// ===== verilog/dqcsr_bank.sv
// Function
// - Bank decoded over the APB register bus at 0x28000 above the window base.
// - Window base holds upper 13 bits of a 512 KiB aligned window.
// - Window base only affects decoding for APB or AHB-Lite interfaces.
// - Hold clear: writing 1 pulses soft reset for exactly one cycle.
// - Hold set: soft reset stays asserted until software writes 0.
// - Soft reset only reaches application logic, never the serial link.
// - Descriptor ring base holds upper 20 bits, low 12 bits read zero.
// - Status ring base holds upper 20 bits, low 12 bits read zero.
// - Status depth is 9 bits at 24:16; software uses 2 to 256.
// - Descriptor depth is 9 bits at 8:0; software uses 2 to 256.
// - Device advances the 8-bit descriptor fetch index on each fetch.
// - Fetch index wraps to zero after depth minus one.
// - Equal indices mean descriptor ring empty; no fetch then.
// - Post index one behind fetch index means descriptor ring full.
// - Device advances the status post index after each status write unless the status ring is full.
// - Status post index wraps to zero after depth minus one.
// - Update flags pulse when fetch index or status post index changes.
`timescale 1ns/1ps
`default_nettype none
module dqcsr_bank (
    // Clock and bus reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    // Register interface kind strap
    input  wire dqcsr_pkg::dqcsr_if_t reg_if_kind_in,
    // APB slave
    input  wire logic [31:0]          paddr_in,
    input  wire logic                 psel_in,
    input  wire logic                 penable_in,
    input  wire logic                 pwrite_in,
    input  wire logic [31:0]          pwdata_in,
    input  wire logic [3:0]           pstrb_in,
    output logic [31:0]               prdata_out,
    output logic                      pready_out,
    output logic                      pslverr_out,
    // Core ring events
    input  wire logic                 desc_fetch_in,
    input  wire logic                 stat_post_in,
    output logic                      desc_updated_out,
    output logic                      stat_updated_out,
    output dqcsr_pkg::dqcsr_ring_t    desc_ring_out,
    output dqcsr_pkg::dqcsr_ring_t    stat_ring_out,
    // Window and soft reset
    output logic [12:0]               win_base_out,
    output logic                      soft_rst_out
);
    logic [12:0] win_base;
    logic        hold_rst;
    logic        soft_rst;
    logic [19:0] dbase;
    logic [19:0] cbase;
    logic [8:0]  ddepth;
    logic [8:0]  cdepth;
    logic [7:0]  dfetch;
    logic [7:0]  dpost;
    logic [7:0]  cpost;
    logic [7:0]  ccons;
    logic [31:0] wmask;
    logic [31:0] next_rdata;
    logic        next_err;
    logic        win_hit;
    logic        bank_hit;
    logic        mapped;
    logic        wr;
    logic [4:0]  ofs;
    logic        d_empty;
    logic        d_full;
    logic        c_empty;
    logic        c_full;
    logic [7:0]  d_next;
    logic [7:0]  c_next;
    logic [7:0]  dp_next;
    logic        d_moved;
    logic        c_moved;

    // Advance an index, wrapping after depth minus one
    function automatic logic [7:0] step(input logic [7:0] idx, input logic [8:0] depth);
        if ({1'b0, idx} == depth - 9'h001)
            return 8'h00;
        else
            return idx + 8'h01;
    endfunction

    // Byte lanes from the write strobes
    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_lane
            assign wmask[8*i +: 8] = {8{pstrb_in[i]}};
        end
    endgenerate

    assign win_hit = (reg_if_kind_in == dqcsr_pkg::DQCSR_IF_OTHER) ||
                     (paddr_in[31:dqcsr_pkg::WIN_LSB] == win_base);
    assign bank_hit = paddr_in[dqcsr_pkg::WIN_LSB-1:dqcsr_pkg::BANK_LSB] ==
                      dqcsr_pkg::BANK_OFS[dqcsr_pkg::WIN_LSB-1:dqcsr_pkg::BANK_LSB];
    assign ofs = paddr_in[4:0];
    assign mapped = win_hit && bank_hit && (ofs == dqcsr_pkg::OFS_WIN ||
                    ofs == dqcsr_pkg::OFS_RST || ofs == dqcsr_pkg::OFS_DBASE ||
                    ofs == dqcsr_pkg::OFS_CBASE || ofs == dqcsr_pkg::OFS_DEPTH ||
                    ofs == dqcsr_pkg::OFS_DIDX || ofs == dqcsr_pkg::OFS_CIDX);
    assign wr = psel_in && penable_in && pwrite_in && mapped;
    // Zero wait states: every access completes in its first access cycle
    assign pready_out = 1'b1;

    // read mux, reserved ranges as zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (ofs)
            dqcsr_pkg::OFS_WIN:   next_rdata = {win_base, 19'h00000};
            dqcsr_pkg::OFS_RST:   next_rdata = {hold_rst, 30'h0000_0000, soft_rst};
            dqcsr_pkg::OFS_DBASE: next_rdata = {dbase, 12'h000};
            dqcsr_pkg::OFS_CBASE: next_rdata = {cbase, 12'h000};
            dqcsr_pkg::OFS_DEPTH: next_rdata = {7'h00, cdepth, 7'h00, ddepth};
            dqcsr_pkg::OFS_DIDX:  next_rdata = {8'h00, dfetch, 8'h00, dpost};
            dqcsr_pkg::OFS_CIDX:  next_rdata = {8'h00, cpost, 8'h00, ccons};
            default:              next_rdata = 32'h0000_0000;
        endcase
        if (!mapped)
            next_rdata = 32'h0000_0000;
        next_err = !mapped;
    end

    // Read data and error are captured in the setup phase
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            prdata_out  <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end
        else if (psel_in && !penable_in)
        begin
            prdata_out  <= pwrite_in ? 32'h0000_0000 : next_rdata;
            pslverr_out <= next_err;
        end
        else if (!psel_in)
        begin
            pslverr_out <= 1'b0;
        end
    end

    // window base, upper 13 bits only
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            win_base <= dqcsr_pkg::WIN_RST;
        else if (wr && ofs == dqcsr_pkg::OFS_WIN)
            win_base <= (win_base & ~wmask[31:19]) | (pwdata_in[31:19] & wmask[31:19]);
    end
    assign win_base_out = win_base;

    // soft reset; hold value taken from the same write
    // drives application logic only, the link is never touched here
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            hold_rst <= 1'b0;
            soft_rst <= 1'b0;
        end
        else if (wr && ofs == dqcsr_pkg::OFS_RST)
        begin
            if (pstrb_in[3])
                hold_rst <= pwdata_in[dqcsr_pkg::HOLD_BIT];
            if (pstrb_in[0])
                soft_rst <= pwdata_in[dqcsr_pkg::RST_BIT];
            else if (!hold_rst)
                soft_rst <= 1'b0;
        end
        else if (!hold_rst)
        begin
            soft_rst <= 1'b0;
        end
    end
    assign soft_rst_out = soft_rst;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            dbase <= dqcsr_pkg::DBASE_RST;
            cbase <= dqcsr_pkg::CBASE_RST;
        end
        else
        begin
            if (wr && ofs == dqcsr_pkg::OFS_DBASE)
                dbase <= (dbase & ~wmask[31:12]) | (pwdata_in[31:12] & wmask[31:12]);
            if (wr && ofs == dqcsr_pkg::OFS_CBASE)
                cbase <= (cbase & ~wmask[31:12]) | (pwdata_in[31:12] & wmask[31:12]);
        end
    end

    // ring depths; values outside 2..256 are software's fault
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ddepth <= dqcsr_pkg::DDEPTH_RST;
            cdepth <= dqcsr_pkg::CDEPTH_RST;
        end
        else if (wr && ofs == dqcsr_pkg::OFS_DEPTH)
        begin
            ddepth <= (ddepth & ~wmask[8:0]) | (pwdata_in[8:0] & wmask[8:0]);
            cdepth <= (cdepth & ~wmask[24:16]) | (pwdata_in[24:16] & wmask[24:16]);
        end
    end

    // Ring conditions
    assign d_next  = step(dfetch, ddepth);
    assign c_next  = step(cpost, cdepth);
    assign dp_next = step(dpost, ddepth);
    assign d_empty = dfetch == dpost;
    // full when post is one behind fetch
    assign d_full  = dp_next == dfetch;
    assign c_empty = cpost == ccons;
    assign c_full  = c_next == ccons;

    // post index written by the master as given
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            dpost <= dqcsr_pkg::IDX_RST;
        else if (wr && ofs == dqcsr_pkg::OFS_DIDX && pstrb_in[0])
            dpost <= pwdata_in[7:0];
    end

    // consume index written by the master
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            ccons <= dqcsr_pkg::IDX_RST;
        else if (wr && ofs == dqcsr_pkg::OFS_CIDX && pstrb_in[0])
            ccons <= pwdata_in[7:0];
    end

    // fetch index; a fetch on an empty ring is dropped
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            dfetch <= dqcsr_pkg::IDX_RST;
        else if (desc_fetch_in && !d_empty)
            dfetch <= d_next;
    end

    // status post index; a full ring holds it still
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            cpost <= dqcsr_pkg::IDX_RST;
        else if (stat_post_in && !c_full)
            cpost <= c_next;
    end

    // update flags, one cycle after the index moved; a staging flop keeps them plain logic
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            d_moved          <= 1'b0;
            c_moved          <= 1'b0;
            desc_updated_out <= 1'b0;
            stat_updated_out <= 1'b0;
        end
        else
        begin
            d_moved          <= desc_fetch_in && !d_empty;
            c_moved          <= stat_post_in && !c_full;
            desc_updated_out <= d_moved;
            stat_updated_out <= c_moved;
        end
    end

    // Ring views for the core
    assign desc_ring_out = '{base: dbase, depth: ddepth, prod: dpost, cons: dfetch,
                             empty: d_empty, full: d_full};
    assign stat_ring_out = '{base: cbase, depth: cdepth, prod: cpost, cons: ccons,
                             empty: c_empty, full: c_full};

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    AST_PULSE_ONE: assert property (
        soft_rst && !$past(soft_rst) && !hold_rst |=> !soft_rst)
        else $error("soft reset pulse longer than one cycle");
    AST_HOLD_KEEP: assert property (
        soft_rst && hold_rst && !(wr && ofs == dqcsr_pkg::OFS_RST) |=> soft_rst)
        else $error("held soft reset released without a write");
    AST_WRAP_FETCH: assert property (
        desc_fetch_in && !d_empty && {1'b0, dfetch} == ddepth - 9'h001 |=> dfetch == 8'h00)
        else $error("fetch index did not wrap");
    AST_EMPTY_STILL: assert property (
        d_empty |=> dfetch == $past(dfetch))
        else $error("fetch index moved on an empty ring");
    AST_FULL_FLAG: assert property (
        d_full == (dfetch != 8'h00 ? dpost == dfetch - 8'h01 : {1'b0, dpost} == ddepth - 9'h001))
        else $error("descriptor full flag wrong");
    AST_STAT_STEP: assert property (
        stat_post_in && !c_full && cpost != 8'hff |=> cpost != $past(cpost))
        else $error("status index did not advance");
    AST_STAT_WRAP: assert property (
        stat_post_in && !c_full && {1'b0, cpost} == cdepth - 9'h001 |=> cpost == 8'h00)
        else $error("status index did not wrap");
    AST_UPD_FLAG: assert property (
        desc_fetch_in && !d_empty |=> ##1 desc_updated_out)
        else $error("descriptor update flag missing");
    AST_RSV_ZERO: assert property (
        psel_in && penable_in && !pwrite_in && ofs == dqcsr_pkg::OFS_DIDX |->
        prdata_out[31:24] == 8'h00 && prdata_out[15:8] == 8'h00)
        else $error("reserved bits read nonzero");
    AST_MISS_ERR: assert property (
        psel_in && !penable_in && !mapped |=> pslverr_out)
        else $error("unmapped access not flagged");
    AST_PULSE_READ: assert property (
        !hold_rst && soft_rst && !(wr && ofs == dqcsr_pkg::OFS_RST) |=> ##1
        !soft_rst || $past(wr, 1))
        else $error("reset bit still reads one");

    COV_PULSE: cover property (!hold_rst ##1 soft_rst ##1 !soft_rst);
    COV_DFULL: cover property (d_full ##[1:20] d_empty);
    COV_CFULL: cover property (stat_post_in && c_full);
    COV_WRAP:  cover property (desc_fetch_in && !d_empty && d_next == 8'h00);
endmodule
`default_nettype wire

// ===== verif/dqcsr_host.sv
`timescale 1ns/1ps
`default_nettype none
module dqcsr_host (
    // Clock
    input  wire logic        clk_in,
    // APB master side
    output logic [31:0]      paddr_out,
    output logic             psel_out,
    output logic             penable_out,
    output logic             pwrite_out,
    output logic [31:0]      pwdata_out,
    output logic [3:0]       pstrb_out,
    input  wire logic [31:0] prdata_in,
    input  wire logic        pready_in,
    input  wire logic        pslverr_in
);
    logic [7:0] post_idx;
    logic       last_err;

    // Idle bus at time zero
    initial
    begin
        {paddr_out, psel_out, penable_out, pwrite_out, pwdata_out, pstrb_out} = '0;
        post_idx = 8'h00;
        last_err = 1'b0;
    end

    // One APB transfer, request held until pready is seen at an edge or 16 edges have passed
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        @(posedge clk_in);
        psel_out <= 1'b1;
        paddr_out <= a;
        pwrite_out <= wr;
        pwdata_out <= d;
        pstrb_out <= 4'hf;
        @(posedge clk_in);
        penable_out <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready_in !== 1'b1 && n < 16);
        q = prdata_in;
        last_err = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        // Released address and data lines show the inverse, so stale values cannot pass for valid
        paddr_out <= ~a;
        pwdata_out <= ~d;
    endtask

    task automatic post_desc(input logic [31:0] a, input logic [8:0] depth, output logic ok);
        logic [31:0] q;
        logic [7:0]  nxt;
        xfer(1'b0, a, 32'h0000_0000, q);
        nxt = ({1'b0, post_idx} == depth - 9'h001) ? 8'h00 : post_idx + 8'h01;
        ok = (nxt != q[23:16]);
        if (ok)
        begin
            post_idx = nxt;
            xfer(1'b1, a, {24'h000000, nxt}, q);
        end
    endtask
endmodule
`default_nettype wire

// ===== verif/tb_dma_queue_csr_bank.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dma_queue_csr_bank;
    logic clk_in, rst_in, fetch, spost, ok;
    logic [31:0] paddr, pwdata, prdata, q, rst_cnt;
    logic psel, penable, pwrite, pready, pslverr, d_upd, s_upd, soft_rst;
    logic [3:0] pstrb;
    logic [12:0] win_cur, win_out;
    dqcsr_pkg::dqcsr_if_t kind;
    dqcsr_pkg::dqcsr_ring_t d_ring, s_ring;
    int n_fail, comparisons;

    dqcsr_host host_u (.clk_in(clk_in), .paddr_out(paddr), .psel_out(psel),
        .penable_out(penable), .pwrite_out(pwrite), .pwdata_out(pwdata), .pstrb_out(pstrb),
        .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));
    dqcsr_bank dut_u (.clk_in(clk_in), .rst_in(rst_in), .reg_if_kind_in(kind),
        .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .desc_fetch_in(fetch), .stat_post_in(spost),
        .desc_updated_out(d_upd), .stat_updated_out(s_upd), .desc_ring_out(d_ring),
        .stat_ring_out(s_ring), .win_base_out(win_out), .soft_rst_out(soft_rst));

    // 200 MHz clock
    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    // Count cycles of application reset
    always @(posedge clk_in)
        if (soft_rst === 1'b1)
            rst_cnt <= rst_cnt + 32'h1;

    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        chk32({31'h0, g}, {31'h0, e});
    endtask

    function automatic logic [31:0] ad(input logic [4:0] o);
        return {win_cur, 19'h0} + dqcsr_pkg::BANK_OFS + {27'h0, o};
    endfunction

    task automatic wr(input logic [4:0] o, input logic [31:0] d);
        host_u.xfer(1'b1, ad(o), d, q);
    endtask

    task automatic rd_chk(input logic [4:0] o, input logic [31:0] e, input logic err);
        host_u.xfer(1'b0, ad(o), 32'h0, q);
        chk32(q, e);
        chk1(host_u.last_err, err);
    endtask

    // One-cycle core event; flag expected two edges later
    task automatic pulse(input logic is_desc, input logic e);
        @(posedge clk_in);
        fetch <= is_desc;
        spost <= ~is_desc;
        @(posedge clk_in);
        fetch <= 1'b0;
        spost <= 1'b0;
        @(posedge clk_in);
        #1 chk1(is_desc ? d_upd : s_upd, e);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the sequence needs
    initial
    begin
        repeat (5000) @(posedge clk_in);
        n_fail++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        {rst_in, fetch, spost, win_cur, rst_cnt, n_fail, comparisons} = '0;
        kind = dqcsr_pkg::DQCSR_IF_APB;
        rst_in = 1'b1;
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        rd_chk(5'h14, 32'h0100_0100, 1'b0);
        rd_chk(5'h00, 32'h0, 1'b0);
        rd_chk(5'h04, 32'h0, 1'b0);
        rd_chk(5'h0c, 32'h0, 1'b0);
        rd_chk(5'h10, 32'h0, 1'b0);
        rd_chk(5'h18, 32'h0, 1'b0);
        wr(5'h0c, 32'hffff_ffff);
        rd_chk(5'h0c, 32'hffff_f000, 1'b0);
        chk32({12'h0, d_ring.base}, 32'h000f_ffff);
        wr(5'h10, 32'hffff_ffff);
        rd_chk(5'h10, 32'hffff_f000, 1'b0);
        chk32({12'h0, s_ring.base}, 32'h000f_ffff);
        // Legal depths only; reserved bits written as ones must not stick
        wr(5'h14, 32'hfeff_fe02);
        rd_chk(5'h14, 32'h00ff_0002, 1'b0);
        chk32({23'h0, d_ring.depth}, 32'h0000_0002);
        chk32({23'h0, s_ring.depth}, 32'h0000_00ff);
        wr(5'h18, 32'hffff_ff00);
        rd_chk(5'h18, 32'h0, 1'b0);
        wr(5'h1c, 32'hffff_ff00);
        rd_chk(5'h1c, 32'h0, 1'b0);
        rd_chk(5'h08, 32'h0, 1'b1);
        rd_chk(5'h02, 32'h0, 1'b1);
        wr(5'h14, 32'h0003_0004);
        repeat (4) host_u.post_desc(ad(5'h18), 9'h004, ok);
        chk1(ok, 1'b0);
        chk1(d_ring.full, 1'b1);
        repeat (3) pulse(1'b1, 1'b1);
        chk1(d_ring.empty, 1'b1);
        pulse(1'b1, 1'b0);
        rd_chk(5'h18, 32'h0003_0003, 1'b0);
        host_u.post_desc(ad(5'h18), 9'h004, ok);
        pulse(1'b1, 1'b1);
        rd_chk(5'h18, 32'h0, 1'b0);
        repeat (2) pulse(1'b0, 1'b1);
        chk1(s_ring.full, 1'b1);
        pulse(1'b0, 1'b0);
        rd_chk(5'h1c, 32'h0002_0000, 1'b0);
        wr(5'h1c, 32'h0000_0002);
        pulse(1'b0, 1'b1);
        rd_chk(5'h1c, 32'h0000_0002, 1'b0);
        wr(5'h04, 32'h0000_0001);
        repeat (4) @(posedge clk_in);
        chk32(rst_cnt, 32'h1);
        rd_chk(5'h04, 32'h0, 1'b0);
        wr(5'h04, 32'h8000_0001);
        repeat (8) @(posedge clk_in);
        chk1(soft_rst, 1'b1);
        rd_chk(5'h04, 32'h8000_0001, 1'b0);
        rd_chk(5'h0c, 32'hffff_f000, 1'b0);
        wr(5'h04, 32'h8000_0000);
        repeat (2) @(posedge clk_in);
        chk1(soft_rst, 1'b0);
        wr(5'h00, 32'hffff_ffff);
        win_cur = 13'h1fff;
        // The write lands in the edge the task returns on; let it settle
        @(posedge clk_in);
        chk32({19'h0, win_out}, 32'h1fff);
        rd_chk(5'h00, 32'hfff8_0000, 1'b0);
        win_cur = 13'h0000;
        rd_chk(5'h0c, 32'h0, 1'b1);
        @(posedge clk_in) kind <= dqcsr_pkg::DQCSR_IF_OTHER;
        rd_chk(5'h0c, 32'hffff_f000, 1'b0);
        @(posedge clk_in) kind <= dqcsr_pkg::DQCSR_IF_AHBL;
        win_cur = 13'h1fff;
        wr(5'h00, 32'h0);
        win_cur = 13'h0000;
        rd_chk(5'h00, 32'h0, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
